// >>> core/crr_pkg.sv
// constants for the clip limit and return address register bank
package crr_pkg;
	// apb byte offsets of the registers
	localparam logic [7:0] OFS_USER_MIN_X = 8'h00;
	localparam logic [7:0] OFS_USER_MIN_Y = 8'h04;
	localparam logic [7:0] OFS_USER_MAX_X = 8'h08;
	localparam logic [7:0] OFS_USER_MAX_Y = 8'h0C;
	localparam logic [7:0] OFS_SYS_MAX_X = 8'h10;
	localparam logic [7:0] OFS_SYS_MAX_Y = 8'h14;
	localparam logic [7:0] OFS_RTN_HIGH = 8'h18;
	localparam logic [7:0] OFS_RTN_LOW = 8'h1C;
	// decoded register index, also the drawing-side coordinate select
	localparam logic [3:0] IDX_USER_MIN_X = 4'h0;
	localparam logic [3:0] IDX_USER_MIN_Y = 4'h1;
	localparam logic [3:0] IDX_USER_MAX_X = 4'h2;
	localparam logic [3:0] IDX_USER_MAX_Y = 4'h3;
	localparam logic [3:0] IDX_SYS_MAX_X = 4'h4;
	localparam logic [3:0] IDX_SYS_MAX_Y = 4'h5;
	localparam logic [3:0] IDX_RTN_HIGH = 4'h6;
	localparam logic [3:0] IDX_RTN_LOW = 4'h7;
	localparam logic [3:0] IDX_NONE = 4'hF;
	localparam int NUM_COORD = 6;
	// field layouts
	localparam int COORD_W = 13;
	localparam int RETURN_ADDRESS_HIGH_W = 7;
	localparam int RETURN_ADDRESS_HIGH_LSB = 0;
	localparam int RETURN_ADDRESS_LOW_W = 15;
	localparam int RETURN_ADDRESS_LOW_LSB = 1;
	localparam int RADDR_W = 23;
	// values after reset of the bus slave
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
	localparam logic PREADY_RST = 1'b0;
	localparam logic PSLVERR_RST = 1'b0;
endpackage

// >>> core/crr_coord_reg.sv
// one clip coordinate held through reset, loaded by the drawing logic
`timescale 1ns/10ps
`default_nettype none
module crr_coord_reg #(
	parameter int W = 13
) (
	// clock
	input wire logic clk_in,
	// load from drawing logic
	input wire logic load_in,
	input wire logic [W-1:0] value_in,
	// held value
	output var logic [W-1:0] value_out
);
	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;

	// only drawing logic changes it; the bus never does
	always_comb begin
		value_nxt = load_in ? value_in : value_r;
	end

	// no reset on purpose: contents survive a reset
	always_ff @(posedge clk_in) begin
		value_r <= value_nxt;
	end

	assign value_out = value_r;
endmodule
`default_nettype wire

// >>> core/crr_rtn_reg.sv
// one return address field, written by software with byte strobes
`timescale 1ns/10ps
`default_nettype none
module crr_rtn_reg #(
	parameter int W = 7,
	parameter int LSB = 0
) (
	// clock
	input wire logic clk_in,
	// bus write
	input wire logic wr_in,
	input wire logic [1:0] strb_in,
	input wire logic [15:0] wdata_in,
	// held field
	output var logic [W-1:0] field_out
);
	logic [W-1:0] field_r;
	logic [W-1:0] field_nxt;

	// each field bit follows the byte lane it sits in
	always_comb begin
		field_nxt = field_r;
		for (int b = 0; b < W; b++) begin
			if (wr_in && strb_in[(LSB + b) / 8]) begin
				field_nxt[b] = wdata_in[LSB + b];
			end
		end
	end

	// no reset: the address is kept through a reset
	always_ff @(posedge clk_in) begin
		field_r <= field_nxt;
	end

	assign field_out = field_r;
endmodule
`default_nettype wire

// >>> core/crr_regs.sv
// clip limit and return address register bank on apb
//
// Operation
// RQ1: user clip min x, min y, max x, max y are 16-bit registers readable but not writable.
// RQ2: bits 15 to 13 of every user clip register read as zero.
// RQ3: user clip values are not touched by reset and start undefined.
// RQ4: system clip max x and max y are 16-bit registers readable but not writable.
// RQ5: bits 15 to 13 of both system clip registers read as zero.
// RQ6: system clip values are not touched by reset.
// RQ7: return address high and low are 16-bit registers readable and writable.
// RQ8: address bits 22..16 come from high bits 6..0, bits 15..1 from low bits 15..1.
// RQ9: the return address is a word address, so byte bit 0 is always zero.
// RQ10: software writes zero to high bits 15..7 and low bit 0; those read undefined.
// RQ11: both return address fields keep their contents through reset.
// RQ12: each clip coordinate is a 13-bit unsigned field in bits 12..0 loaded by drawing logic.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module crr_regs #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [3:0] PSTRB_IN,
	output var logic [31:0] PRDATA_OUT,
	output var logic PREADY_OUT,
	output var logic PSLVERR_OUT,
	// clip load from drawing logic
	input wire logic CLIP_LOAD_IN,
	input wire logic [3:0] CLIP_SEL_IN,
	input wire logic [12:0] CLIP_VALUE_IN,
	// held values toward drawing and display list logic
	output var logic [12:0] USER_MIN_X_OUT,
	output var logic [12:0] USER_MIN_Y_OUT,
	output var logic [12:0] USER_MAX_X_OUT,
	output var logic [12:0] USER_MAX_Y_OUT,
	output var logic [12:0] SYS_MAX_X_OUT,
	output var logic [12:0] SYS_MAX_Y_OUT,
	output var logic [22:0] RETURN_ADDR_OUT
);
	// byte offset to register index; unmapped gives IDX_NONE
	function automatic logic [3:0] dec_index(input logic [ADDR_W-1:0] a);
		logic [7:0] ofs;
		ofs = 8'(a);
		if (ADDR_W > 8 && (a >> 8) != '0) begin
			dec_index = crr_pkg::IDX_NONE;
		end else if (ofs == crr_pkg::OFS_USER_MIN_X) begin
			dec_index = crr_pkg::IDX_USER_MIN_X;
		end else if (ofs == crr_pkg::OFS_USER_MIN_Y) begin
			dec_index = crr_pkg::IDX_USER_MIN_Y;
		end else if (ofs == crr_pkg::OFS_USER_MAX_X) begin
			dec_index = crr_pkg::IDX_USER_MAX_X;
		end else if (ofs == crr_pkg::OFS_USER_MAX_Y) begin
			dec_index = crr_pkg::IDX_USER_MAX_Y;
		end else if (ofs == crr_pkg::OFS_SYS_MAX_X) begin
			dec_index = crr_pkg::IDX_SYS_MAX_X;
		end else if (ofs == crr_pkg::OFS_SYS_MAX_Y) begin
			dec_index = crr_pkg::IDX_SYS_MAX_Y;
		end else if (ofs == crr_pkg::OFS_RTN_HIGH) begin
			dec_index = crr_pkg::IDX_RTN_HIGH;
		end else if (ofs == crr_pkg::OFS_RTN_LOW) begin
			dec_index = crr_pkg::IDX_RTN_LOW;
		end else begin
			dec_index = crr_pkg::IDX_NONE;
		end
	endfunction

	logic [crr_pkg::COORD_W-1:0] coord_q [crr_pkg::NUM_COORD];
	logic [crr_pkg::RETURN_ADDRESS_HIGH_W-1:0] return_address_high_q;
	logic [crr_pkg::RETURN_ADDRESS_LOW_W-1:0] return_address_low_q;
	logic [3:0] setup_idx;
	logic [3:0] access_idx;
	logic setup_phase;
	logic wr_go;
	logic [15:0] rd_word;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// coordinates: drawing logic loads them, bus writes never reach them
	for (genvar i = 0; i < crr_pkg::NUM_COORD; i++) begin : g_coord
		crr_coord_reg #(
			.W(crr_pkg::COORD_W)
		) u_coord (
			.clk_in(CLK_IN), // [RQ3] [RQ6] no reset reaches the coordinates
			.load_in(CLIP_LOAD_IN && (CLIP_SEL_IN == 4'(i))), // [RQ12] [RQ1] [RQ4]
			.value_in(CLIP_VALUE_IN),
			.value_out(coord_q[i])
		);
	end

	// bus phase decode
	assign setup_phase = PSEL_IN && !PENABLE_IN;
	assign setup_idx = dec_index(PADDR_IN);
	assign access_idx = dec_index(PADDR_IN);
	// a write lands only at the completing access edge
	assign wr_go = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN && !pslverr_r;

	// return address fields; reserved bits are simply not stored
	crr_rtn_reg #(
		.W(crr_pkg::RETURN_ADDRESS_HIGH_W),
		.LSB(crr_pkg::RETURN_ADDRESS_HIGH_LSB)
	) u_rtn_high (
		.clk_in(CLK_IN),
		.wr_in(wr_go && access_idx == crr_pkg::IDX_RTN_HIGH), // [RQ7] [RQ11]
		.strb_in(PSTRB_IN[1:0]),
		.wdata_in(PWDATA_IN[15:0]),
		.field_out(return_address_high_q)
	);
	crr_rtn_reg #(
		.W(crr_pkg::RETURN_ADDRESS_LOW_W),
		.LSB(crr_pkg::RETURN_ADDRESS_LOW_LSB)
	) u_rtn_low (
		.clk_in(CLK_IN),
		.wr_in(wr_go && access_idx == crr_pkg::IDX_RTN_LOW), // [RQ7] [RQ11]
		.strb_in(PSTRB_IN[1:0]),
		.wdata_in(PWDATA_IN[15:0]),
		.field_out(return_address_low_q)
	);

	// read value; reserved bits come back as zero, the safe reading of "undefined"
	always_comb begin
		rd_word = 16'h0000;
		if (setup_idx == crr_pkg::IDX_RTN_HIGH) begin
			rd_word = {9'h000, return_address_high_q}; // [RQ8] [RQ10]
		end else if (setup_idx == crr_pkg::IDX_RTN_LOW) begin
			rd_word = {return_address_low_q, 1'b0}; // [RQ8] [RQ10]
		end else if (setup_idx < crr_pkg::IDX_RTN_HIGH) begin
			rd_word = {3'h0, coord_q[setup_idx[2:0]]}; // [RQ2] [RQ5]
		end
	end

	// zero wait: data and ready are set up in the setup cycle
	always_comb begin
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (setup_phase) begin
			pready_nxt = 1'b1;
			pslverr_nxt = (setup_idx == crr_pkg::IDX_NONE);
			prdata_nxt = PWRITE_IN ? 32'h0000_0000 : {16'h0000, rd_word};
		end
	end

	// bus answer flops are the only ones with a reset
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			prdata_r <= crr_pkg::PRDATA_RST;
			pready_r <= crr_pkg::PREADY_RST;
			pslverr_r <= crr_pkg::PSLVERR_RST;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// outputs straight from the holding flops
	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = pready_r;
	assign PSLVERR_OUT = pslverr_r;
	assign USER_MIN_X_OUT = coord_q[crr_pkg::IDX_USER_MIN_X[2:0]];
	assign USER_MIN_Y_OUT = coord_q[crr_pkg::IDX_USER_MIN_Y[2:0]];
	assign USER_MAX_X_OUT = coord_q[crr_pkg::IDX_USER_MAX_X[2:0]];
	assign USER_MAX_Y_OUT = coord_q[crr_pkg::IDX_USER_MAX_Y[2:0]];
	assign SYS_MAX_X_OUT = coord_q[crr_pkg::IDX_SYS_MAX_X[2:0]];
	assign SYS_MAX_Y_OUT = coord_q[crr_pkg::IDX_SYS_MAX_Y[2:0]];
	// word address: byte bit 0 tied low
	assign RETURN_ADDR_OUT = {return_address_high_q, return_address_low_q, 1'b0}; // [RQ8] [RQ9]

	// known-value flags for the reset checks: each held value is unknown until
	// its first load, so before that there is nothing for a reset to keep
	logic umy_seen_r;
	logic umy_seen_nxt;
	logic smy_seen_r;
	logic smy_seen_nxt;
	logic return_address_high_seen_r;
	logic return_address_high_seen_nxt;
	logic return_address_low_seen_r;
	logic return_address_low_seen_nxt;

	// set by the first full load or write, then sticky
	always_comb begin
		umy_seen_nxt = umy_seen_r
			|| (CLIP_LOAD_IN && CLIP_SEL_IN == crr_pkg::IDX_USER_MAX_Y);
		smy_seen_nxt = smy_seen_r
			|| (CLIP_LOAD_IN && CLIP_SEL_IN == crr_pkg::IDX_SYS_MAX_Y);
		return_address_high_seen_nxt = return_address_high_seen_r
			|| (wr_go && access_idx == crr_pkg::IDX_RTN_HIGH && PSTRB_IN[0]);
		return_address_low_seen_nxt = return_address_low_seen_r
			|| (wr_go && access_idx == crr_pkg::IDX_RTN_LOW && PSTRB_IN[1:0] == 2'h3);
	end

	// no reset, like the values they follow, so a mid-run reset leaves them set
	always_ff @(posedge CLK_IN) begin
		umy_seen_r <= umy_seen_nxt;
		smy_seen_r <= smy_seen_nxt;
		return_address_high_seen_r <= return_address_high_seen_nxt;
		return_address_low_seen_r <= return_address_low_seen_nxt;
	end

	// setup is always answered at the next edge
	a_ready_next: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ7]
		setup_phase |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("ready not one cycle after setup");

	// user clip reads carry zero in the reserved bits
	a_user_resv_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ2]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN && access_idx < 4'h4
		|-> PRDATA_OUT[15:13] == 3'h0)
		else $error("user clip reserved bits not zero");

	// system clip reads return the held value
	a_sys_read_val: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ5]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& access_idx == crr_pkg::IDX_SYS_MAX_X && !$past(CLIP_LOAD_IN)
		|-> PRDATA_OUT == {19'h00000, SYS_MAX_X_OUT})
		else $error("system clip read wrong");

	// a bus write never moves a user clip coordinate
	a_user_no_write: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ1]
		wr_go && access_idx == crr_pkg::IDX_USER_MIN_X && !CLIP_LOAD_IN
		|=> $stable(USER_MIN_X_OUT))
		else $error("user clip changed by bus write");

	// reset leaves user clip contents alone
	a_user_keep_rst: assert property (@(posedge CLK_IN) // [RQ3]
		RST_IN && !CLIP_LOAD_IN && umy_seen_r |=> $stable(USER_MAX_Y_OUT))
		else $error("user clip changed by reset");

	// reset leaves system clip contents alone
	a_sys_keep_rst: assert property (@(posedge CLK_IN) // [RQ6]
		RST_IN && !CLIP_LOAD_IN && smy_seen_r |=> $stable(SYS_MAX_Y_OUT))
		else $error("system clip changed by reset");

	// drawing load lands in the selected coordinate only
	a_clip_load: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ12]
		CLIP_LOAD_IN && CLIP_SEL_IN == crr_pkg::IDX_SYS_MAX_X
		|=> SYS_MAX_X_OUT == $past(CLIP_VALUE_IN) && $stable(USER_MAX_Y_OUT))
		else $error("clip load missed");

	// low field write reaches address bits 15..1
	a_rtn_low_map: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ8]
		wr_go && access_idx == crr_pkg::IDX_RTN_LOW && PSTRB_IN[1:0] == 2'h3
		|=> RETURN_ADDR_OUT[15:0] == {$past(PWDATA_IN[15:1]), 1'b0})
		else $error("return low not mapped");

	// high field write reaches address bits 22..16
	a_rtn_high_map: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ8]
		wr_go && access_idx == crr_pkg::IDX_RTN_HIGH && PSTRB_IN[0]
		|=> RETURN_ADDR_OUT[22:16] == $past(PWDATA_IN[6:0]))
		else $error("return high not mapped");

	// word address keeps byte bit low
	a_rtn_word: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ9]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& access_idx == crr_pkg::IDX_RTN_LOW |-> PRDATA_OUT[0] == 1'b0)
		else $error("return low bit 0 set");

	// reset leaves the return address alone
	a_rtn_keep_rst: assert property (@(posedge CLK_IN) // [RQ11]
		RST_IN && return_address_high_seen_r && return_address_low_seen_r |=> $stable(RETURN_ADDR_OUT))
		else $error("return address changed by reset");

	// unmapped offsets answer with an error
	a_unmapped_err: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		setup_phase && setup_idx == crr_pkg::IDX_NONE |=> PSLVERR_OUT && PREADY_OUT)
		else $error("unmapped access not flagged");

	// user clip reads return the held value
	a_user_read_val: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ1]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& access_idx == crr_pkg::IDX_USER_MAX_Y && !$past(CLIP_LOAD_IN)
		|-> PRDATA_OUT == {19'h00000, USER_MAX_Y_OUT})
		else $error("user clip read wrong");

	// system clip reads carry zero in the reserved bits
	a_sys_resv_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ5]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& (access_idx == crr_pkg::IDX_SYS_MAX_X || access_idx == crr_pkg::IDX_SYS_MAX_Y)
		|-> PRDATA_OUT[15:13] == 3'h0)
		else $error("system clip reserved bits not zero");

	// a bus write never moves a system clip coordinate
	a_sys_no_write: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ4]
		wr_go && access_idx == crr_pkg::IDX_SYS_MAX_Y && !CLIP_LOAD_IN
		|=> $stable(SYS_MAX_Y_OUT))
		else $error("system clip changed by bus write");

	// high field reads back what the address output holds
	a_rtn_high_back: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ7]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& access_idx == crr_pkg::IDX_RTN_HIGH |-> PRDATA_OUT[6:0] == RETURN_ADDR_OUT[22:16])
		else $error("return high read wrong");

	// low field reads back what the address output holds
	a_rtn_low_back: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ7]
		PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
		&& access_idx == crr_pkg::IDX_RTN_LOW |-> PRDATA_OUT[15:1] == RETURN_ADDR_OUT[15:1])
		else $error("return low read wrong");

	// a lane-0 write leaves the upper lane of the low field alone
	a_rtn_lane_keep: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ7]
		wr_go && access_idx == crr_pkg::IDX_RTN_LOW && PSTRB_IN[1:0] == 2'h1
		|=> RETURN_ADDR_OUT[15:8] == $past(RETURN_ADDR_OUT[15:8])
		&& RETURN_ADDR_OUT[7:1] == $past(PWDATA_IN[7:1]))
		else $error("return low lane write wrong");

	// a refused write leaves the return address alone
	a_err_no_write: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [RQ7]
		PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PSLVERR_OUT
		|=> $stable(RETURN_ADDR_OUT))
		else $error("refused write changed return address");
endmodule
`default_nettype wire

// >>> verification/crr_host.sv
// apb master model standing for the host processor
`timescale 1ns/10ps
`default_nettype none
module crr_host (
	// clock
	input wire logic clk_in,
	// apb master side
	output var logic psel_out,
	output var logic penable_out,
	output var logic pwrite_out,
	output var logic [7:0] paddr_out,
	output var logic [31:0] pwdata_out,
	output var logic [3:0] pstrb_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	// idle bus from time zero
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0000_0000;
		pstrb_out = 4'h0;
	end
	// one transfer, entered just after a rising edge; one idle cycle after it
	// keeps a following call from touching psel in the same time step
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic err);
		psel_out <= 1'b1;
		pwrite_out <= wr;
		paddr_out <= a;
		pwdata_out <= d;
		pstrb_out <= s;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do @(posedge clk_in); while (pready_in !== 1'b1);
		rd = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// >>> verification/crr_regs_test.sv
// self-checking bench for the clip limit and return address bank
`timescale 1ns/10ps
`default_nettype none
module crr_regs_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, clip_load;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, clip_sel;
	logic [12:0] clip_value;
	logic [12:0] coord [6];
	logic [12:0] exp_c [6];
	logic [22:0] raddr;
	int err_count = 0;
	int comparisons = 0;

	// host model and the bank under test
	crr_host i_crr_host (.clk_in(clk), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb),
		.prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
	crr_regs #(.ADDR_W(8)) i_crr_regs (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.CLIP_LOAD_IN(clip_load), .CLIP_SEL_IN(clip_sel), .CLIP_VALUE_IN(clip_value),
		.USER_MIN_X_OUT(coord[0]), .USER_MIN_Y_OUT(coord[1]), .USER_MAX_X_OUT(coord[2]),
		.USER_MAX_Y_OUT(coord[3]), .SYS_MAX_X_OUT(coord[4]), .SYS_MAX_Y_OUT(coord[5]),
		.RETURN_ADDR_OUT(raddr));

	// 40 mhz clock
	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// mask drops read bits whose value is left open
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] m, input logic [31:0] exp, input logic exp_e);
		logic [31:0] r;
		logic e;
		i_crr_host.xfer(wr, a, d, s, r, e);
		if (!wr) check($sformatf("rdata_%h", a), exp, r & m);
		check($sformatf("slverr_%h", a), {31'h0, exp_e}, {31'h0, e});
	endtask

	task automatic load(input logic [3:0] sel, input logic [12:0] v);
		clip_load <= 1'b1;
		clip_sel <= sel;
		clip_value <= v;
		@(posedge clk);
		clip_load <= 1'b0;
		@(posedge clk);
	endtask

	// load each coordinate, try to overwrite it, read it back
	task automatic test_clip;
		for (int i = 0; i < 6; i++) begin
			exp_c[i] = 13'h1FFF - 13'(i) * 13'h0333;
			load(4'(i), exp_c[i]);
			bus(1'b1, 8'(4 * i), 32'hFFFF_FFFF, 4'hF, 32'h0, 32'h0, 1'b0);
			bus(1'b0, 8'(4 * i), 32'h0, 4'h0, 32'hFFFF_FFFF, {19'h0, exp_c[i]}, 1'b0);
			check("coord_port", {19'h0, exp_c[i]}, {19'h0, coord[i]});
		end
		// a select outside the six coordinates loads nothing
		load(4'hF, 13'h0AAA);
		for (int i = 0; i < 6; i++) begin
			check("coord_unsel", {19'h0, exp_c[i]}, {19'h0, coord[i]});
		end
	endtask

	// return address fields, lane strobes and the word address output
	task automatic test_rtn;
		bus(1'b1, 8'h18, 32'h0000_0055, 4'h3, 32'h0, 32'h0, 1'b0);
		bus(1'b1, 8'h1C, 32'h0000_ABCE, 4'h3, 32'h0, 32'h0, 1'b0);
		bus(1'b0, 8'h18, 32'h0, 4'h0, 32'h0000_007F, 32'h0000_0055, 1'b0);
		bus(1'b0, 8'h1C, 32'h0, 4'h0, 32'h0000_FFFE, 32'h0000_ABCE, 1'b0);
		check("raddr", 32'h0055_ABCE, {9'h0, raddr});
		bus(1'b1, 8'h1C, 32'h0000_1230, 4'h1, 32'h0, 32'h0, 1'b0);
		check("raddr_lane", 32'h0055_AB30, {9'h0, raddr});
		bus(1'b1, 8'h1C, 32'h0000_5600, 4'h2, 32'h0, 32'h0, 1'b0);
		check("raddr_lane_hi", 32'h0055_5630, {9'h0, raddr});
	endtask

	// a reset in mid-run leaves every held value alone
	task automatic test_reset;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			check("coord_kept", {19'h0, exp_c[i]}, {19'h0, coord[i]});
		end
		check("raddr_kept", 32'h0055_5630, {9'h0, raddr});
		bus(1'b0, 8'h10, 32'h0, 4'h0, 32'hFFFF_FFFF, {19'h0, exp_c[4]}, 1'b0);
	endtask

	// unmapped offsets answer with an error and change nothing
	task automatic test_unmapped;
		bus(1'b0, 8'h20, 32'h0, 4'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		bus(1'b1, 8'h38, 32'h0000_0011, 4'h3, 32'h0, 32'h0, 1'b1);
		check("raddr_unmapped", 32'h0055_5630, {9'h0, raddr});
	endtask

	task automatic complete_run;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// main sequence, inputs settled at time zero and reset held 5 cycles
	initial begin
		clip_load = 1'b0;
		clip_sel = 4'h0;
		clip_value = 13'h0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		test_clip();
		test_rtn();
		test_reset();
		test_unmapped();
		complete_run();
	end

	// the tests need well under 200 cycles; 2000 means a hang
	initial begin
		#50000;
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
